//--- shared/ppsm_pkg.sv
/*
 * Constants and types for the parallel port strap mux: the line count, the
 * index of each line, reset and idle pad levels, and the bus-release states.
 * Assumes nothing of its surroundings.
 */
package ppsm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Lines handled by the mux.
    localparam int unsigned LINE_COUNT = 5;
    localparam int unsigned LINE_10    = 0;
    localparam int unsigned LINE_11    = 1;
    localparam int unsigned LINE_12    = 2;
    localparam int unsigned LINE_13    = 3;
    localparam int unsigned LINE_14    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Strap levels and pad levels.
    localparam logic STRAP_IO_MODE  = 1'b0;
    localparam logic STRAP_MEM_MODE = 1'b1;
    localparam logic PAD_IDLE_LEVEL = 1'b1;
    localparam logic PAD_OE_OFF     = 1'b0;
    localparam logic PAD_OE_ON      = 1'b1;
    localparam logic RESET_MODE     = STRAP_IO_MODE;

    ////////////////////////////////////////////////////////////////////////////
    // Bus-release handshake states.
    typedef enum logic [2:0] {
        HOLD_IDLE = 3'h1,
        HOLD_WAIT = 3'h2,
        HOLD_HELD = 3'h4
    } ppsm_hold_t;

endpackage

//--- verilog/ppsm_line_sel.sv
/*
 * Function select for one muxed port line: picks the pad drive and enable
 * from the general-purpose bit or the memory-interface signal.
 * Assumes the caller registers the result and gives the latched strap mode.
 */
`timescale 1ns/1ps

module ppsm_line_sel #(
    parameter bit MEM_IS_INPUT = 1'b0
) (
    // Selection state
    input  wire logic mode_mem,
    input  wire logic in_reset,
    input  wire logic bus_float,
    // Function sources
    input  wire logic io_o,
    input  wire logic io_oe,
    input  wire logic mem_o,
    // Pad drive
    output logic      sel_o,
    output logic      sel_oe
);

    always_comb begin
        sel_o  = ppsm_pkg::PAD_IDLE_LEVEL;
        sel_oe = ppsm_pkg::PAD_OE_OFF;
        if (in_reset) begin
            sel_o  = ppsm_pkg::PAD_IDLE_LEVEL;
            sel_oe = ppsm_pkg::PAD_OE_OFF;
        end else if (mode_mem) begin
            // The request line never drives, so a host may own it at all times.
            if (!MEM_IS_INPUT) begin
                sel_o  = mem_o;
                sel_oe = !bus_float;
            end
        end else begin
            sel_o  = io_o;
            sel_oe = io_oe;
        end
    end

endmodule

//--- verilog/ppsm_mux.sv
/*
 * Reset-strap pin mux for parallel port lines 10 to 14, with the bus-release
 * handshake for the memory interface.
 * Assumes the general-purpose direction register resets to input, that the
 * memory interface holds its control outputs at 1 when idle, and that all
 * inputs are synchronous to ref_clk.
 */
//
// Overview of operation
// - The strap level seen during reset picks the function: low for general I/O, high for the memory interface.
// - The chosen function is frozen when reset is released and never changes until the next reset.
// - Line 10 carries I/O bit 30, or byte enable 2 in memory mode.
// - Line 11 carries I/O bit 31, or byte enable 3 in memory mode.
// - Line 12 carries I/O bit 32, or the SDRAM clock enable in memory mode.
// - Line 13 carries I/O bit 33, or the synchronous output enable of space 3 in memory mode.
// - Line 14 carries I/O bit 34, or is an input for the bus-release request in memory mode.
// - A line in general I/O use comes out of reset as an input and drives only when software sets it so.
// - Memory outputs float during reset and are driven at 1 once reset ends.
// - The space 3 output enable lets a FIFO hang on that space with no glue.
// - A granted request is answered with the grant low and the memory bus floated.
`timescale 1ns/1ps

module ppsm_mux #(
    parameter int unsigned LINES = ppsm_pkg::LINE_COUNT
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Strap
    input  wire logic             boot_strap_select_pin,
    // Pads
    input  wire logic             port_line_10_i,
    output logic                  port_line_10_o,
    output logic                  port_line_10_oe,
    input  wire logic             port_line_11_i,
    output logic                  port_line_11_o,
    output logic                  port_line_11_oe,
    input  wire logic             port_line_12_i,
    output logic                  port_line_12_o,
    output logic                  port_line_12_oe,
    input  wire logic             port_line_13_i,
    output logic                  port_line_13_o,
    output logic                  port_line_13_oe,
    input  wire logic             port_line_14_i,
    output logic                  port_line_14_o,
    output logic                  port_line_14_oe,
    // General-purpose bits 30 to 34, bit 0 is bit 30
    input  wire logic [LINES-1:0] port_io_out,
    input  wire logic [LINES-1:0] port_io_dir,
    output logic      [LINES-1:0] port_io_in,
    // Memory interface
    input  wire logic             mem_byte_enable_2,
    input  wire logic             mem_byte_enable_3,
    input  wire logic             sdram_clock_enable_out,
    input  wire logic             sync_output_enable_space3,
    input  wire logic             mem_bus_idle,
    output logic                  bus_release_request_n,
    output logic                  bus_release_grant_n,
    output logic                  mem_bus_float,
    output logic                  mem_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic                 mode_mem;
        ppsm_pkg::ppsm_hold_t hold;
        logic [LINES-1:0]     pad_o;
        logic [LINES-1:0]     pad_oe;
        logic [LINES-1:0]     io_in;
    } ppsm_state_t;

    ppsm_state_t      st_q;
    ppsm_state_t      st_d;
    logic [LINES-1:0] pad_i;
    logic [LINES-1:0] mem_o;
    logic [LINES-1:0] sel_o;
    logic [LINES-1:0] sel_oe;
    logic             req_seen;

    assign pad_i = {port_line_14_i, port_line_13_i, port_line_12_i, port_line_11_i, port_line_10_i};
    // Line 14 has no memory output; its slot is the idle level.
    assign mem_o = {ppsm_pkg::PAD_IDLE_LEVEL, sync_output_enable_space3, sdram_clock_enable_out,
                    mem_byte_enable_3, mem_byte_enable_2};
    // The request is read from the pad only in memory mode, so a toggling I/O bit cannot steal the bus.
    assign req_seen = st_q.mode_mem && !pad_i[ppsm_pkg::LINE_14];

    ////////////////////////////////////////////////////////////////////////////
    // Per-line function select.
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            ppsm_line_sel #(
                .MEM_IS_INPUT (gi == ppsm_pkg::LINE_14)
            ) u_sel (
                .mode_mem  (st_q.mode_mem),
                .in_reset  (rst),
                .bus_float (st_q.hold == ppsm_pkg::HOLD_HELD),
                .io_o      (port_io_out[gi]),
                .io_oe     (port_io_dir[gi]),
                .mem_o     (mem_o[gi]),
                .sel_o     (sel_o[gi]),
                .sel_oe    (sel_oe[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        st_d        = st_q;
        st_d.pad_o  = sel_o;
        st_d.pad_oe = sel_oe;
        st_d.io_in  = pad_i;
        if (rst) begin
            // Caught on every reset edge, so the last one before release wins.
            st_d.mode_mem = boot_strap_select_pin;
            st_d.hold     = ppsm_pkg::HOLD_IDLE;
            st_d.io_in    = '0;
        end else begin
            st_d.mode_mem = st_q.mode_mem;
            case (st_q.hold)
                ppsm_pkg::HOLD_IDLE: begin
                    if (req_seen) begin
                        st_d.hold = ppsm_pkg::HOLD_WAIT;
                    end
                end
                ppsm_pkg::HOLD_WAIT: begin
                    // The grant waits for the bus to go quiet so no access is cut short.
                    if (!req_seen) begin
                        st_d.hold = ppsm_pkg::HOLD_IDLE;
                    end else if (mem_bus_idle) begin
                        st_d.hold = ppsm_pkg::HOLD_HELD;
                    end
                end
                ppsm_pkg::HOLD_HELD: begin
                    if (!req_seen) begin
                        st_d.hold = ppsm_pkg::HOLD_IDLE;
                    end
                end
                default: begin
                    st_d.hold = ppsm_pkg::HOLD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q.mode_mem <= st_d.mode_mem;
            st_q.hold     <= ppsm_pkg::HOLD_IDLE;
            st_q.pad_o    <= {LINES{ppsm_pkg::PAD_IDLE_LEVEL}};
            st_q.pad_oe   <= {LINES{ppsm_pkg::PAD_OE_OFF}};
            st_q.io_in    <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign port_line_10_o        = st_q.pad_o[ppsm_pkg::LINE_10];
    assign port_line_10_oe       = st_q.pad_oe[ppsm_pkg::LINE_10];
    assign port_line_11_o        = st_q.pad_o[ppsm_pkg::LINE_11];
    assign port_line_11_oe       = st_q.pad_oe[ppsm_pkg::LINE_11];
    assign port_line_12_o        = st_q.pad_o[ppsm_pkg::LINE_12];
    assign port_line_12_oe       = st_q.pad_oe[ppsm_pkg::LINE_12];
    assign port_line_13_o        = st_q.pad_o[ppsm_pkg::LINE_13];
    assign port_line_13_oe       = st_q.pad_oe[ppsm_pkg::LINE_13];
    assign port_line_14_o        = st_q.pad_o[ppsm_pkg::LINE_14];
    assign port_line_14_oe       = st_q.pad_oe[ppsm_pkg::LINE_14];
    assign port_io_in            = st_q.mode_mem ? '0 : st_q.io_in;
    assign bus_release_request_n = !req_seen;
    assign bus_release_grant_n   = (st_q.hold != ppsm_pkg::HOLD_HELD);
    assign mem_bus_float         = (st_q.hold == ppsm_pkg::HOLD_HELD);
    assign mem_mode              = st_q.mode_mem;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic first_q;
    always_ff @(posedge ref_clk) begin
        first_q <= rst;
    end

    sequence s_release;
        first_q ##0 !rst;
    endsequence

    // Pads are registered, so the first edge after release and the edge after a float still show the old drive.
    sequence s_mem_drive;
        mem_mode && !first_q && !mem_bus_float && !$past(mem_bus_float);
    endsequence

    // The idle level must be seen on the edge where the request is already waiting.
    sequence s_req_idle;
        mem_mode && !bus_release_request_n ##1 !bus_release_request_n && mem_bus_idle;
    endsequence

    a_strap_pick: assert property (s_release |-> mem_mode == $past(boot_strap_select_pin))
        else $error("Mode does not match strap seen in last reset cycle.");
    a_mode_frozen: assert property (!first_q |-> $stable(mem_mode))
        else $error("Mode changed outside reset.");
    a_line10_map: assert property (s_mem_drive
                                   |-> port_line_10_oe && port_line_10_o == $past(mem_byte_enable_2))
        else $error("Line 10 does not carry byte enable 2.");
    a_line11_io: assert property (!mem_mode && !first_q
                                  |-> port_line_11_oe == $past(port_io_dir[1])
                                      && port_line_11_o == $past(port_io_out[1]))
        else $error("Line 11 does not carry I/O bit 31.");
    a_line12_map: assert property (s_mem_drive
                                   |-> port_line_12_oe && port_line_12_o == $past(sdram_clock_enable_out))
        else $error("Line 12 does not carry the clock enable.");
    a_line13_map: assert property (s_mem_drive
                                   |-> port_line_13_oe && port_line_13_o == $past(sync_output_enable_space3))
        else $error("Line 13 does not carry the space 3 output enable.");
    a_line14_input: assert property (mem_mode |-> !port_line_14_oe ##1 !port_line_14_oe)
        else $error("Line 14 drives in memory mode.");
    a_io_start_input: assert property (s_release ##0 !mem_mode
                                       |-> !port_line_10_oe ##1 port_line_10_oe == $past(port_io_dir[0]))
        else $error("I/O line does not follow its direction after reset.");
    a_mem_first_drive: assert property (s_release ##0 mem_mode |-> ##1 port_line_11_oe && port_line_11_o)
        else $error("Memory output not driven high after reset.");
    a_grant_float: assert property (!bus_release_grant_n
                                    |-> mem_bus_float && !$past(bus_release_request_n)
                                        && ($past(bus_release_grant_n) || !port_line_13_oe))
        else $error("Grant without floated bus or request.");
    a_grant_timing: assert property (s_req_idle |-> ##1 !bus_release_grant_n)
        else $error("Request with idle bus not granted in time.");

endmodule

//--- dv/ppsm_far_side.sv
/*
 * Far-side model: the external bus host and the pad loads on lines 10 to 14.
 * Assumes pad values and enables from the mux and commands from the bench.
 */
`timescale 1ns/1ps

module ppsm_far_side (
    // Clock
    input  wire logic       ref_clk,
    // Mux pads
    input  wire logic [4:0] pad_o,
    input  wire logic [4:0] pad_oe,
    // Bench commands
    input  wire logic       host_on,
    input  wire logic       host_req,
    input  wire logic [4:0] ext_en,
    input  wire logic [4:0] ext_val,
    // Resolved pad levels
    output logic      [4:0] pad_lvl
);
    logic flip_q = 1'b0;

    // A floating pad toggles so that a stale level never passes for a driven one.
    always_ff @(posedge ref_clk) begin
        flip_q <= ~flip_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (pad_oe[i]) begin
                pad_lvl[i] = pad_o[i];
            end else if (host_on && i == 4) begin
                pad_lvl[i] = ~host_req;
            end else if (ext_en[i]) begin
                pad_lvl[i] = ext_val[i];
            end else begin
                pad_lvl[i] = flip_q;
            end
        end
    end
endmodule

//--- dv/testbench.sv
/*
 * Self-checking bench for the strap mux: both strap modes, pad mapping and the
 * bus-release handshake. Assumes the far-side model resolves the pad levels.
 */
`timescale 1ns/1ps

module testbench;
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       strap   = 1'b0;
    logic [4:0] io_out  = 5'h00;
    logic [4:0] io_dir  = 5'h00;
    logic [3:0] mem_sig = 4'hF;
    logic       idle    = 1'b1;
    logic       host_on = 1'b0;
    logic       host_rq = 1'b0;
    logic [4:0] ext_en  = 5'h00;
    logic [4:0] ext_val = 5'h00;
    wire logic [4:0] p_o, p_oe, lvl, io_in;
    wire logic       req_n, gnt_n, flt, mmode;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    ppsm_mux dut (.ref_clk(ref_clk), .rst(rst), .boot_strap_select_pin(strap),
        .port_line_10_i(lvl[0]), .port_line_10_o(p_o[0]), .port_line_10_oe(p_oe[0]),
        .port_line_11_i(lvl[1]), .port_line_11_o(p_o[1]), .port_line_11_oe(p_oe[1]),
        .port_line_12_i(lvl[2]), .port_line_12_o(p_o[2]), .port_line_12_oe(p_oe[2]),
        .port_line_13_i(lvl[3]), .port_line_13_o(p_o[3]), .port_line_13_oe(p_oe[3]),
        .port_line_14_i(lvl[4]), .port_line_14_o(p_o[4]), .port_line_14_oe(p_oe[4]),
        .port_io_out(io_out), .port_io_dir(io_dir), .port_io_in(io_in),
        .mem_byte_enable_2(mem_sig[0]), .mem_byte_enable_3(mem_sig[1]),
        .sdram_clock_enable_out(mem_sig[2]), .sync_output_enable_space3(mem_sig[3]),
        .mem_bus_idle(idle), .bus_release_request_n(req_n), .bus_release_grant_n(gnt_n),
        .mem_bus_float(flt), .mem_mode(mmode));

    ppsm_far_side far (.ref_clk(ref_clk), .pad_o(p_o), .pad_oe(p_oe), .host_on(host_on),
        .host_req(host_rq), .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(lvl));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string name, logic [4:0] exp, logic [4:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // The strap is flipped as reset ends, so a late sample would show up.
    task automatic do_reset(logic s);
        rst = 1'b1;
        strap = s;
        step(5);
        chk("oe in reset", 5'h00, p_oe);
        chk("o in reset", 5'h1F, p_o);
        rst = 1'b0;
        strap = ~s;
        step(1);
        chk("mode", {4'h0, s}, {4'h0, mmode});
    endtask

    task automatic t_io;
        do_reset(1'b0);
        chk("io oe after reset", 5'h00, p_oe);
        io_dir = 5'h1F;
        io_out = 5'h0A;
        mem_sig = 4'h0;
        step(1);
        chk("io oe", 5'h1F, p_oe);
        chk("io o", 5'h0A, p_o);
        io_out = 5'h15;
        step(1);
        chk("io o", 5'h15, p_o);
        io_dir = 5'h00;
        ext_en = 5'h1F;
        ext_val = 5'h0B;
        step(2);
        chk("io in", 5'h0B, io_in);
        ext_en = 5'h00;
        host_on = 1'b1;
        host_rq = 1'b1;
        step(4);
        chk("req ignored", 5'h01, {4'h0, req_n});
        chk("no grant", 5'h01, {4'h0, gnt_n});
        chk("mode kept", 5'h00, {4'h0, mmode});
        host_on = 1'b0;
        host_rq = 1'b0;
        mem_sig = 4'hF;
    endtask

    task automatic t_mem;
        do_reset(1'b1);
        chk("mem oe", 5'h0F, p_oe);
        chk("mem o", 5'h1F, p_o);
        io_dir = 5'h1F;
        io_out = 5'h00;
        for (int i = 0; i < 4; i++) begin
            mem_sig = 4'hF & ~(4'h1 << i);
            step(1);
            chk("mem map", {1'b1, mem_sig}, p_o);
            chk("mem oe", 5'h0F, p_oe);
        end
        mem_sig = 4'hF;
        // Line 14 is held high here so that no bus request is raised before the handshake test.
        ext_val = 5'h10;
        ext_en = 5'h10;
        step(2);
        chk("io in mem", 5'h00, io_in);
        ext_en = 5'h00;
        chk("mode kept", 5'h01, {4'h0, mmode});
    endtask

    task automatic t_hold;
        host_on = 1'b1;
        host_rq = 1'b1;
        #1;
        chk("request", 5'h00, {4'h0, req_n});
        step(2);
        chk("grant", 5'h00, {4'h0, gnt_n});
        chk("float", 5'h01, {4'h0, flt});
        step(1);
        chk("oe held", 5'h00, p_oe);
        host_rq = 1'b0;
        step(1);
        chk("grant off", 5'h01, {4'h0, gnt_n});
        step(1);
        chk("oe back", 5'h0F, p_oe);
        idle = 1'b0;
        host_rq = 1'b1;
        step(4);
        chk("grant waits", 5'h01, {4'h0, gnt_n});
        idle = 1'b1;
        for (int k = 0; k < 4 && gnt_n !== 1'b0; k++) begin
            step(1);
        end
        chk("late grant", 5'h00, {4'h0, gnt_n});
        host_rq = 1'b0;
        step(2);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The whole run needs about 40 cycles; the ceiling leaves ample margin.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        t_io();
        t_mem();
        t_hold();
        summarize();
    end
endmodule
